// file: src/toq_pkg.sv
// shared constants and types for the timed output queue
package toq_pkg;

    // ======================================================
    // queue sizing and entry layout
    localparam int          FIFO_DEPTH       = 16;
    localparam int          BATCH_MAX        = 5;
    localparam int          ENTRY_BYTES      = 4;
    localparam int          LAST_MARK_BIT    = 6;
    localparam int          STATE_DO0_BIT    = 7;
    localparam int          NUM_OUTPUTS      = 4;

    // ======================================================
    // queue status fields
    localparam int          QSTS_CLOSED_BIT  = 7;
    localparam int          QSTS_FULL_BIT    = 1;
    localparam int          QSTS_EMPTY_BIT   = 0;
    localparam int          NDUE_PEND_BIT    = 7;

    // ======================================================
    // diagnostic record selectors
    localparam logic [15:0] RS_FULL          = 16'h0001;
    localparam logic [15:0] RS_SHORT         = 16'h0000;
    localparam logic [15:0] CAN_IX_FULL      = 16'h2F01;
    localparam logic [15:0] CAN_IX_SHORT     = 16'h2F00;
    localparam logic [15:0] ECAT_IX          = 16'h5005;
    localparam logic [7:0]  SX_FIRST         = 8'h02;
    localparam logic [7:0]  SX_LAST_BYTE     = 8'h11;
    localparam logic [7:0]  SX_TIMESTAMP     = 8'h13;

    // ======================================================
    // diagnostic record layout
    localparam logic [4:0]  REC_LEN          = 5'h14;
    localparam logic [4:0]  REC_SHORT_LEN    = 5'h04;
    localparam logic [4:0]  OFF_MODULE_INFO  = 5'h01;
    localparam logic [4:0]  OFF_CH_KIND      = 5'h04;
    localparam logic [4:0]  OFF_DIAG_BITS    = 5'h05;
    localparam logic [4:0]  OFF_CH_COUNT     = 5'h06;
    localparam logic [4:0]  OFF_TIMESTAMP    = 5'h10;
    localparam logic [2:0]  TS_BYTES         = 3'h4;

    // ======================================================
    // diagnostic record reset values
    localparam logic [7:0]  RST_RESERVED     = 8'h00;
    localparam logic [7:0]  RST_MODULE_INFO  = 8'h1F;
    localparam logic [7:0]  RST_CH_KIND      = 8'h72;
    localparam logic [7:0]  RST_DIAG_BITS    = 8'h00;
    localparam logic [7:0]  RST_CH_COUNT     = 8'h04;
    localparam logic [31:0] RST_TIMESTAMP    = 32'h0000_0000;

    // ======================================================
    // types
    typedef enum logic [1:0] {
        ACC_RECORD_SET,
        ACC_CAN_INDEX,
        ACC_ECAT_SUBINDEX
    } toq_access_t;

    typedef struct packed {
        logic [7:0]  state;
        logic [7:0]  sequence_number;
        logic [15:0] switch_time_us;
    } toq_entry_t;

    typedef struct packed {
        toq_access_t kind;
        logic [15:0] object_index;
        logic [7:0]  object_subindex;
        logic [4:0]  byte_idx;
    } toq_diag_req_t;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [7:0]  data;
    } toq_diag_rsp_t;

endpackage

// file: src/toq_timed_output_queue.sv
// timed output queue with fifo and diagnostic record server
`timescale 1ns/1ps

// ==========================================================
// parameterised fifo with registered full and empty
module toq_fifo #(
    parameter int WIDTH   = 32,
    parameter int DEPTH   = 16,
    parameter int LEVEL_W = $clog2(DEPTH + 1)
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic [WIDTH-1:0]   in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic      [WIDTH-1:0]   out_data,
    output logic      [LEVEL_W-1:0] level
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [LEVEL_W-1:0] FULL_LVL = LEVEL_W'(DEPTH);
    localparam logic [PTR_W-1:0]   LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0]   mem [DEPTH];
    logic [PTR_W-1:0]   wr_ptr_reg;
    logic [PTR_W-1:0]   rd_ptr_reg;
    logic [LEVEL_W-1:0] level_reg;
    logic [LEVEL_W-1:0] level_next;
    logic               full_reg;
    logic               empty_reg;
    wire                push;
    wire                pop;

    assign push      = in_valid && !full_reg;
    assign pop       = out_ready && !empty_reg;
    assign in_ready  = !full_reg;
    assign out_valid = !empty_reg;
    assign out_data  = mem[rd_ptr_reg];
    assign level     = level_reg;

    always_comb begin
        level_next = level_reg;
        if (push && !pop) begin
            level_next = level_reg + 1'b1;
        end else if (pop && !push) begin
            level_next = level_reg - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg  <= '0;
            full_reg   <= 1'b0;
            empty_reg  <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0
                                                       : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0
                                                       : rd_ptr_reg + 1'b1;
            end
            level_reg <= level_next;
            full_reg  <= (level_next == FULL_LVL);
            empty_reg <= (level_next == '0);
        end
    end
endmodule

// ==========================================================
// top level
// Operation
// - entries are applied strictly in stored order, removed on the same edge
// - no interrupt output; diagnostic record is read only
// - record set 01h gives full record, 00h only first 4 bytes
// - object index 2F01h gives full record, 2F00h first 4 bytes
// - index 5005h exposes each record field at subindex from 02h
// - module info 1Fh, channel kind 72h, zero bits, reserved 00h
// - channel count reads 04h for the four timed outputs
// - entry is state byte, sequence byte, 16-bit switch time
// - written entries go straight into the queue
// - timestamp holds ticker sampled when the record is generated
module toq_timed_output_queue #(
    parameter int DEPTH = toq_pkg::FIFO_DEPTH
) (
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    input  wire logic [31:0]            ticker_us,
    input  wire logic                   img_valid,
    input  wire toq_pkg::toq_entry_t    img_entry,
    output logic                        img_ready,
    output logic [3:0]                  do_out,
    output logic [7:0]                  last_written_sequence,
    output logic [7:0]                  next_due_sequence,
    output logic [7:0]                  queue_status,
    output logic [7:0]                  pending_entry_count,
    input  wire logic                   diag_req_valid,
    input  wire toq_pkg::toq_diag_req_t diag_req,
    output toq_pkg::toq_diag_rsp_t      diag_rsp
);
    localparam int ENTRY_W = $bits(toq_pkg::toq_entry_t);
    localparam int LEVEL_W = $clog2(DEPTH + 1);

    typedef enum logic [1:0] {
        BATCH_IDLE,
        BATCH_OPEN,
        BATCH_CLOSED
    } toq_batch_t;

    // ======================================================
    // queue
    logic                 head_valid;
    logic [ENTRY_W-1:0]   head_bits;
    logic [LEVEL_W-1:0]   level;
    toq_pkg::toq_entry_t  head;
    wire                  push;
    wire                  due;

    assign head = toq_pkg::toq_entry_t'(head_bits);
    assign push = img_valid && img_ready;

    assign due = head_valid
              && (ticker_us[15:0] == head.switch_time_us);

    toq_fifo #(
        .WIDTH   (ENTRY_W),
        .DEPTH   (DEPTH),
        .LEVEL_W (LEVEL_W)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .in_valid  (img_valid),
        .in_ready  (img_ready),
        .in_data   (img_entry),
        .out_valid (head_valid),
        .out_ready (due),
        .out_data  (head_bits),
        .level     (level)
    );

    // ======================================================
    // output application
    logic [3:0] do_reg;
    wire  [3:0] do_from_head;

    genvar gi;
    generate
        for (gi = 0; gi < toq_pkg::NUM_OUTPUTS; gi++) begin : g_do
            assign do_from_head[gi] =
                head.state[toq_pkg::STATE_DO0_BIT - gi];
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            do_reg <= '0;
        end else if (due) begin
            do_reg <= do_from_head;
        end
    end

    assign do_out = do_reg;

    // ======================================================
    // batch tracking and status
    toq_batch_t batch_reg;
    toq_batch_t batch_next;
    logic [2:0] batch_cnt_reg;
    logic [2:0] batch_cnt_next;
    logic [7:0] last_wr_reg;
    logic [7:0] next_due_reg;
    logic [7:0] qsts_reg;
    logic [7:0] pending_reg;
    wire        marked;
    wire        batch_full;
    wire        closes;

    // marker bit closes a short batch
    assign marked     = img_entry.sequence_number[toq_pkg::LAST_MARK_BIT];
    assign batch_full = (batch_cnt_reg == 3'(toq_pkg::BATCH_MAX - 1));
    assign closes     = push && (marked || batch_full);

    always_comb begin
        batch_next     = batch_reg;
        batch_cnt_next = batch_cnt_reg;
        case (batch_reg)
            BATCH_IDLE, BATCH_CLOSED: begin
                if (push) begin
                    batch_next     = closes ? BATCH_CLOSED : BATCH_OPEN;
                    batch_cnt_next = closes ? 3'h0 : 3'h1;
                end
            end
            BATCH_OPEN: begin
                if (push) begin
                    batch_next     = closes ? BATCH_CLOSED : BATCH_OPEN;
                    batch_cnt_next = closes ? 3'h0 : batch_cnt_reg + 3'h1;
                end
            end
            default: begin
                batch_next     = BATCH_IDLE;
                batch_cnt_next = 3'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            batch_reg     <= BATCH_IDLE;
            batch_cnt_reg <= 3'h0;
        end else begin
            batch_reg     <= batch_next;
            batch_cnt_reg <= batch_cnt_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            last_wr_reg <= 8'h00;
        end else if (push) begin
            last_wr_reg <= img_entry.sequence_number;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            next_due_reg <= 8'h00;
            qsts_reg     <= 8'h00;
            pending_reg  <= 8'h00;
        end else begin
            next_due_reg <= head_valid
                ? (head.sequence_number
                   | (8'h01 << toq_pkg::NDUE_PEND_BIT))
                : 8'h00;
            qsts_reg <= 8'h00;
            qsts_reg[toq_pkg::QSTS_CLOSED_BIT] <=
                (batch_next == BATCH_CLOSED);
            qsts_reg[toq_pkg::QSTS_FULL_BIT]  <= !img_ready;
            qsts_reg[toq_pkg::QSTS_EMPTY_BIT] <= !head_valid;
            pending_reg <= 8'(level);
        end
    end

    assign last_written_sequence = last_wr_reg;
    assign next_due_sequence     = next_due_reg;
    assign queue_status          = qsts_reg;
    assign pending_entry_count   = pending_reg;

    // ======================================================
    // diagnostic record decode
    // returns {ok, record offset}
    function automatic logic [5:0] decode(
        input toq_pkg::toq_diag_req_t r
    );
        logic       ok;
        logic [4:0] off;
        ok  = 1'b0;
        off = r.byte_idx;
        case (r.kind)
            toq_pkg::ACC_RECORD_SET: begin
                if (r.object_index == toq_pkg::RS_FULL) begin
                    ok = r.byte_idx < toq_pkg::REC_LEN;
                end else if (r.object_index == toq_pkg::RS_SHORT) begin
                    ok = r.byte_idx < toq_pkg::REC_SHORT_LEN;
                end
            end
            toq_pkg::ACC_CAN_INDEX: begin
                if (r.object_index == toq_pkg::CAN_IX_FULL) begin
                    ok = r.byte_idx < toq_pkg::REC_LEN;
                end else if (r.object_index == toq_pkg::CAN_IX_SHORT) begin
                    ok = r.byte_idx < toq_pkg::REC_SHORT_LEN;
                end
            end
            toq_pkg::ACC_ECAT_SUBINDEX: begin
                if (r.object_index == toq_pkg::ECAT_IX) begin
                    if (r.object_subindex >= toq_pkg::SX_FIRST
                        && r.object_subindex <= toq_pkg::SX_LAST_BYTE) begin
                        ok  = (r.byte_idx == 5'h00);
                        off = 5'(r.object_subindex - toq_pkg::SX_FIRST);
                    end else if (r.object_subindex
                                 == toq_pkg::SX_TIMESTAMP) begin
                        ok  = r.byte_idx < 5'(toq_pkg::TS_BYTES);
                        off = toq_pkg::OFF_TIMESTAMP + r.byte_idx;
                    end
                end
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return {ok, off};
    endfunction

    // ======================================================
    // diagnostic record contents
    logic [31:0]          ts_reg;
    wire  [5:0]           dec;
    wire                  dec_ok;
    wire  [4:0]           dec_off;
    wire                  gen;
    wire  [31:0]          ts_view;
    logic [7:0]           rec_byte;
    toq_pkg::toq_diag_rsp_t rsp_reg;

    assign dec     = decode(diag_req);
    assign dec_ok  = dec[5];
    assign dec_off = dec[4:0];

    assign gen     = diag_req_valid && dec_ok && (diag_req.byte_idx == 5'h00);
    assign ts_view = gen ? ticker_us : ts_reg;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ts_reg <= toq_pkg::RST_TIMESTAMP;
        end else if (gen) begin
            ts_reg <= ticker_us;
        end
    end

    always_comb begin
        rec_byte = toq_pkg::RST_RESERVED;
        case (dec_off)
            toq_pkg::OFF_MODULE_INFO: rec_byte = toq_pkg::RST_MODULE_INFO;
            toq_pkg::OFF_CH_KIND:     rec_byte = toq_pkg::RST_CH_KIND;
            toq_pkg::OFF_DIAG_BITS:   rec_byte = toq_pkg::RST_DIAG_BITS;
            toq_pkg::OFF_CH_COUNT:    rec_byte = toq_pkg::RST_CH_COUNT;
            default: begin
                if (dec_off >= toq_pkg::OFF_TIMESTAMP) begin
                    rec_byte = ts_view[8*(dec_off[1:0]) +: 8];
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= diag_req_valid;
            rsp_reg.error <= diag_req_valid && !dec_ok;
            rsp_reg.data  <= (diag_req_valid && dec_ok) ? rec_byte : 8'h00;
        end
    end

    assign diag_rsp = rsp_reg;
endmodule

// file: verification/toq_props.sv
// port checker for the timed output queue
`timescale 1ns/1ps

module toq_checker #(
    parameter int DEPTH = 16
) (
    input wire logic                   sys_clk,
    input wire logic                   reset_n,
    input wire logic [31:0]            ticker_us,
    input wire logic                   img_valid,
    input wire toq_pkg::toq_entry_t    img_entry,
    input wire logic                   img_ready,
    input wire logic [3:0]             do_out,
    input wire logic [7:0]             last_written_sequence,
    input wire logic [7:0]             next_due_sequence,
    input wire logic [7:0]             queue_status,
    input wire logic [7:0]             pending_entry_count,
    input wire logic                   diag_req_valid,
    input wire toq_pkg::toq_diag_req_t diag_req,
    input wire toq_pkg::toq_diag_rsp_t diag_rsp
);
    // ======================================================
    // decoded requests
    wire logic rd_rs   = diag_req_valid
                         && diag_req.kind == toq_pkg::ACC_RECORD_SET;
    wire logic rd_can  = diag_req_valid
                         && diag_req.kind == toq_pkg::ACC_CAN_INDEX;
    wire logic rd_ecat = diag_req_valid
                         && diag_req.kind == toq_pkg::ACC_ECAT_SUBINDEX;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ======================================================
    // diagnostic read timing
    property p_rsp_next;
        diag_req_valid |=> diag_rsp.valid;
    endproperty
    a_rsp_next: assert property (p_rsp_next)
        else $error("no response one cycle after read");

    property p_rsp_cause;
        diag_rsp.valid |-> $past(diag_req_valid);
    endproperty
    a_rsp_cause: assert property (p_rsp_cause)
        else $error("response without read");

    // ======================================================
    // record contents
    property p_module_info;
        rd_rs && diag_req.object_index == 16'h0001
        && diag_req.byte_idx == 5'h01
        |=> diag_rsp.data == 8'h1F && !diag_rsp.error;
    endproperty
    a_module_info: assert property (p_module_info)
        else $error("module info byte wrong");

    property p_ch_count;
        rd_ecat && diag_req.object_index == 16'h5005
        && diag_req.object_subindex == 8'h08 && diag_req.byte_idx == 5'h00
        |=> diag_rsp.data == 8'h04 && !diag_rsp.error;
    endproperty
    a_ch_count: assert property (p_ch_count)
        else $error("channel count wrong");

    property p_can_kind;
        rd_can && diag_req.object_index == 16'h2F01
        && diag_req.byte_idx == 5'h04
        |=> diag_rsp.data == 8'h72 && !diag_rsp.error;
    endproperty
    a_can_kind: assert property (p_can_kind)
        else $error("channel kind over index wrong");

    property p_short_limit;
        rd_can && diag_req.object_index == 16'h2F00
        && diag_req.byte_idx >= 5'h04
        |=> diag_rsp.error;
    endproperty
    a_short_limit: assert property (p_short_limit)
        else $error("short record longer than four bytes");

    // ======================================================
    // queue behaviour
    property p_full_ready;
        pending_entry_count == DEPTH |-> !$past(img_ready);
    endproperty
    a_full_ready: assert property (p_full_ready)
        else $error("ready while queue full");

    property p_apply_cause;
        $changed(do_out) |-> pending_entry_count != 8'h00;
    endproperty
    a_apply_cause: assert property (p_apply_cause)
        else $error("outputs changed with empty queue");

    c_full: cover property (pending_entry_count == DEPTH);
    c_refused: cover property (img_valid && !img_ready);
    c_err: cover property (diag_rsp.valid && diag_rsp.error);
    c_apply: cover property ($changed(do_out));
endmodule

// file: verification/toq_head_model.sv
// head module model with running microsecond ticker
`timescale 1ns/1ps

module toq_head_model #(
    parameter int          US_CYCLES = 10,
    parameter logic [31:0] START     = 32'h0000_FF00
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        run,
    output logic      [31:0] ticker_us
);
    logic [7:0] pre_reg;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pre_reg   <= 8'h00;
            ticker_us <= START;
        end else if (run) begin
            if (pre_reg == 8'(US_CYCLES - 1)) begin
                pre_reg   <= 8'h00;
                ticker_us <= ticker_us + 32'h0000_0001;
            end else begin
                pre_reg <= pre_reg + 8'h01;
            end
        end
    end
endmodule

// file: verification/toq_timed_output_queue_tb.sv
// testbench for the timed output queue
`timescale 1ns/1ps

module toq_timed_output_queue_tb;
    localparam int DEPTH = 16;
    logic                   sys_clk        = 1'b0;
    logic                   reset_n        = 1'b0;
    logic                   run            = 1'b1;
    logic                   img_valid      = 1'b0;
    toq_pkg::toq_entry_t    img_entry      = '0;
    logic                   diag_req_valid = 1'b0;
    toq_pkg::toq_diag_req_t diag_req       = '0;
    logic [31:0]            ticker_us;
    logic                   img_ready;
    logic [3:0]             do_out;
    logic [7:0]             last_written_sequence;
    logic [7:0]             next_due_sequence;
    logic [7:0]             queue_status;
    logic [7:0]             pending_entry_count;
    toq_pkg::toq_diag_rsp_t diag_rsp;
    logic [3:0]             exp_do[$];
    toq_pkg::toq_diag_rsp_t exp_rsp[$];
    logic [3:0]             last_do   = 4'h0;
    logic [7:0]             prev_st   = 8'h00;
    logic [31:0]            ts_cap    = 32'h0000_0000;
    logic [7:0]             s;
    logic [15:0]            t;
    int                     error_cnt = 0;
    int                     checks    = 0;

    toq_head_model toq_head_model_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .run(run),
        .ticker_us(ticker_us));

    toq_timed_output_queue #(.DEPTH(DEPTH)) toq_timed_output_queue_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .ticker_us(ticker_us),
        .img_valid(img_valid), .img_entry(img_entry),
        .img_ready(img_ready), .do_out(do_out),
        .last_written_sequence(last_written_sequence),
        .next_due_sequence(next_due_sequence),
        .queue_status(queue_status),
        .pending_entry_count(pending_entry_count),
        .diag_req_valid(diag_req_valid), .diag_req(diag_req),
        .diag_rsp(diag_rsp));

    initial forever #50 sys_clk = ~sys_clk;

    // ======================================================
    // shared tasks
    task automatic fail(input string msg);
        error_cnt++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) fail(msg);
    endtask

    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic nst(output logic [7:0] st);
        st = 8'($urandom);
        if (st[7:4] == prev_st[7:4]) st[7] = ~st[7];
        prev_st = st;
    endtask

    task automatic put_entry(input logic [7:0] st, input logic [7:0] sq,
                             input logic [15:0] tm, input logic exp);
        int n;
        img_entry = '{st, sq, tm};
        img_valid = 1'b1;
        if (exp) exp_do.push_back({st[4], st[5], st[6], st[7]});
        n = 0;
        while (img_ready !== 1'b1 && n < 5000) begin
            step();
            n++;
        end
        if (n == 5000) fail("entry never taken");
        step();
    endtask

    task automatic rd(input toq_pkg::toq_access_t k, input logic [15:0] ix,
                      input logic [7:0] sx, input int idx, input logic err,
                      input int off);
        logic [7:0] d;
        if (idx == 0) ts_cap = ticker_us;
        case (off)
            1: d = 8'h1F;
            4: d = 8'h72;
            6: d = 8'h04;
            16, 17, 18, 19: d = ts_cap[8*(off-16) +: 8];
            default: d = 8'h00;
        endcase
        if (err) d = 8'h00;
        diag_req = '{k, ix, sx, 5'(idx)};
        diag_req_valid = 1'b1;
        exp_rsp.push_back('{1'b1, err, d});
        step();
    endtask

    task automatic rec(input toq_pkg::toq_access_t k, input logic [15:0] ix,
                       input int n, input int lim);
        for (int i = 0; i < n; i++) rd(k, ix, 8'h00, i, i >= lim, i);
    endtask

    task automatic wait_empty;
        int n;
        n = 0;
        while (pending_entry_count !== 8'h00 && n < 5000) begin
            step();
            n++;
        end
        if (n == 5000) fail("queue never drained");
        repeat (3) step();
    endtask

    task automatic print_verdict;
        if (exp_do.size() != 0 || exp_rsp.size() != 0) fail("results left");
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ======================================================
    // result watcher
    always @(negedge sys_clk) begin
        if (reset_n === 1'b1 && diag_rsp.valid === 1'b1) begin
            if (exp_rsp.size() == 0) fail("unexpected response");
            else chk(diag_rsp === exp_rsp.pop_front(), "diag byte");
        end
        if (reset_n === 1'b1 && do_out !== last_do) begin
            if (exp_do.size() == 0) fail("unexpected output change");
            else chk(do_out === exp_do.pop_front(), "outputs");
        end
        last_do = do_out;
    end

    initial begin
        #2000000;
        fail("watchdog expired");
        print_verdict();
    end

    // ======================================================
    // main sequence
    initial begin
        void'($urandom(76));
        repeat (3) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        step();
        chk(do_out === 4'h0 && img_ready === 1'b1, "reset outputs");
        chk(pending_entry_count === 8'h00, "reset count");
        chk(queue_status[0] === 1'b1, "reset empty flag");
        rec(toq_pkg::ACC_RECORD_SET, 16'h0001, 20, 20);
        rec(toq_pkg::ACC_RECORD_SET, 16'h0000, 5, 4);
        rec(toq_pkg::ACC_CAN_INDEX, 16'h2F01, 20, 20);
        rec(toq_pkg::ACC_CAN_INDEX, 16'h2F00, 5, 4);
        for (int i = 2; i < 18; i++) begin
            rd(toq_pkg::ACC_ECAT_SUBINDEX, 16'h5005, 8'(i), 0, 1'b0, i - 2);
        end
        for (int i = 0; i < 4; i++) begin
            rd(toq_pkg::ACC_ECAT_SUBINDEX, 16'h5005, 8'h13, i, 1'b0, 16 + i);
        end
        rd(toq_pkg::ACC_ECAT_SUBINDEX, 16'h5005, 8'h12, 0, 1'b1, 0);
        rd(toq_pkg::ACC_RECORD_SET, 16'h0002, 8'h00, 0, 1'b1, 0);
        diag_req_valid = 1'b0;
        repeat (2) step();
        t = ticker_us[15:0];
        for (int i = 0; i < 3; i++) begin
            nst(s);
            put_entry(s, (i == 2) ? 8'h43 : 8'(i + 1), t + 16'(20 + 10 * i),
                      1'b1);
        end
        img_valid = 1'b0;
        repeat (3) step();
        chk(last_written_sequence === 8'h43, "last sequence");
        chk(pending_entry_count === 8'h03, "pending count");
        chk(next_due_sequence === 8'h81, "next due");
        chk(queue_status[7] === 1'b1, "batch closed");
        wait_empty();
        chk(queue_status[0] === 1'b1, "empty after apply");
        run = 1'b0;
        step();
        t = ticker_us[15:0];
        for (int i = 0; i < 17; i++) begin
            nst(s);
            if (i == 16) begin
                img_valid = 1'b0;
                repeat (3) step();
                chk(img_ready === 1'b0, "full refuses");
                chk(pending_entry_count === 8'h10, "full count");
                chk(queue_status[1] === 1'b1, "full flag");
                chk(queue_status[7] === 1'b0, "batch reopened");
                run = 1'b1;
            end
            put_entry(s, 8'(i), t + 16'(10 + 5 * i), 1'b1);
        end
        img_valid = 1'b0;
        wait_empty();
        chk(queue_status[0] === 1'b1, "drained");
        t = ticker_us[15:0];
        put_entry(8'hF0, 8'h20, t + 16'h0100, 1'b0);
        img_valid = 1'b0;
        step();
        reset_n = 1'b0;
        repeat (2) step();
        reset_n = 1'b1;
        repeat (2) step();
        chk(pending_entry_count === 8'h00, "count after reset");
        print_verdict();
    end
endmodule

bind toq_timed_output_queue toq_checker #(.DEPTH(DEPTH)) toq_checker_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .ticker_us(ticker_us),
    .img_valid(img_valid), .img_entry(img_entry), .img_ready(img_ready),
    .do_out(do_out), .last_written_sequence(last_written_sequence),
    .next_due_sequence(next_due_sequence), .queue_status(queue_status),
    .pending_entry_count(pending_entry_count),
    .diag_req_valid(diag_req_valid), .diag_req(diag_req),
    .diag_rsp(diag_rsp));
